//--- tfi_pkg.sv
// package: register offsets, bit positions and mode codes for timer irq flags
package tfi_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFF_IRQ_ENABLE = 4'h0;
   localparam logic [3:0] OFF_IRQ_FLAGS = 4'h1;
   localparam logic [3:0] OFF_MODE = 4'h2;
   localparam logic [3:0] OFF_COUNTER_LO = 4'h3;
   localparam logic [3:0] OFF_COUNTER_HI = 4'h4;
   localparam logic [3:0] OFF_CAPTURE_LO = 4'h5;
   localparam logic [3:0] OFF_CAPTURE_HI = 4'h6;
   localparam logic [3:0] OFF_COMPARE_A_LO = 4'h7;
   localparam logic [3:0] OFF_COMPARE_A_HI = 4'h8;
   localparam logic [3:0] OFF_COMPARE_B_LO = 4'h9;
   localparam logic [3:0] OFF_COMPARE_B_HI = 4'hA;
   localparam logic [3:0] OFF_COMPARE_C_LO = 4'hB;
   localparam logic [3:0] OFF_COMPARE_C_HI = 4'hC;
   // bit positions shared by flag and enable registers
   localparam int BIT_CAPTURE = 5;
   localparam int BIT_MATCH_C = 3;
   localparam int BIT_MATCH_B = 2;
   localparam int BIT_MATCH_A = 1;
   localparam int BIT_OVERFLOW = 0;
   // implemented bits of the flag and enable registers
   localparam logic [7:0] FLAG_MASK = 8'h2F;
   // reset values
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // waveform mode codes that matter to flag setting
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_CMP_A = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPTURE = 4'hC;
   localparam logic [3:0] MODE_FAST_PWM_CAPTURE = 4'hE;
   localparam logic [3:0] MODE_PHASE_CAPTURE = 4'hA;
   localparam logic [3:0] MODE_PFC_CAPTURE = 4'h8;
   // capture edge choice
   typedef enum logic [0:0] {
      TFI_EDGE_FALL = 1'b0,
      TFI_EDGE_RISE = 1'b1
   } tfi_edge_t;
endpackage

//--- tfi_irq_flags.sv
// timer16 interrupt flags, enables, capture and compare match detection
`timescale 1ns/1ps
`default_nettype none
module tfi_irq_flags (
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   // timer unit
   input wire logic timer_tick_i,
   input wire logic [15:0] counter_value_i,
   input wire logic counter_wrap_i,
   input wire logic pwm_flag_point_i,
   input wire logic capture_input_pin_i,
   input wire logic capture_edge_i,
   input wire logic force_match_a_strobe_i,
   input wire logic force_match_b_strobe_i,
   input wire logic force_match_c_strobe_i,
   // core interrupt logic, then counter write out to the counter unit
   input wire logic global_irq_en_i,
   input wire logic [4:0] vector_ack_i,
   output logic [4:0] irq_req_o,
   output logic irq_o,
   output logic counter_write_o,
   output logic [15:0] counter_wdata_o
);
   // software state
   logic [7:0] enable_reg; // per source enable bits
   logic [7:0] flags_reg; // sticky flags
   logic [3:0] waveform_mode_sel_reg; // waveform mode selection
   logic [15:0] capture_value_reg; // captured counter value
   logic [15:0] compare_a_value_reg;
   logic [15:0] compare_b_value_reg;
   logic [15:0] compare_c_value_reg;
   logic [7:0] counter_wbuf_reg; // low byte held until high byte write
   logic block_match_reg; // counter write pending block
   // pin synchroniser, first stage read only by second
   logic pin_meta_reg;
   logic pin_s2_reg;
   logic pin_s3_reg;
   logic pin_level_reg; // accepted level
   // decoded events
   logic capture_is_top;
   logic pin_event;
   logic top_event;
   logic match_a;
   logic match_b;
   logic match_c;
   logic overflow_event;
   logic [7:0] set_vec;
   logic [7:0] clear_vec;
   logic flags_wr;
   logic [7:0] rdata_next;

   // true for the modes that take top from the capture register
   function automatic logic capture_top_mode(input logic [3:0] mode);
      capture_top_mode = (mode == tfi_pkg::MODE_CTC_CAPTURE) ||
         (mode == tfi_pkg::MODE_FAST_PWM_CAPTURE) ||
         (mode == tfi_pkg::MODE_PHASE_CAPTURE) ||
         (mode == tfi_pkg::MODE_PFC_CAPTURE);
   endfunction

   // equality with the compare word, gated by the tick and the write block
   function automatic logic match_hit(input logic [15:0] cnt,
         input logic [15:0] cmp, input logic tick, input logic blk);
      match_hit = tick && !blk && (cnt == cmp);
   endfunction

   assign capture_is_top = capture_top_mode(waveform_mode_sel_reg);
   assign flags_wr = reg_write_i && (reg_addr_i == tfi_pkg::OFF_IRQ_FLAGS);

   // three stage pin synchroniser
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_meta_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
      end else begin
         pin_meta_reg <= capture_input_pin_i;
         pin_s2_reg <= pin_meta_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // accepted level changes only once stages two and three agree
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_level_reg <= 1'b0;
      end else if (pin_s2_reg == pin_s3_reg) begin
         pin_level_reg <= pin_s3_reg;
      end
   end

   // edge qualified by the selected polarity
   always_comb begin
      if (capture_edge_i == tfi_pkg::TFI_EDGE_RISE) begin
         pin_event = (pin_s3_reg == pin_s2_reg) && pin_s3_reg &&
            !pin_level_reg;
      end else begin
         pin_event = (pin_s3_reg == pin_s2_reg) && !pin_s3_reg &&
            pin_level_reg;
      end
   end

   // capture flag source: pin or top depending on mode
   assign top_event = capture_is_top && timer_tick_i &&
      (counter_value_i == capture_value_reg);

   // match detection on a tick in the same cycle as equality, strobes unused
   // so a forced compare can never raise a match flag
   assign match_a = match_hit(counter_value_i, compare_a_value_reg,
      timer_tick_i, block_match_reg);
   assign match_b = match_hit(counter_value_i, compare_b_value_reg,
      timer_tick_i, block_match_reg);
   assign match_c = match_hit(counter_value_i, compare_c_value_reg,
      timer_tick_i, block_match_reg);

   // overflow source chosen by mode
   always_comb begin
      if ((waveform_mode_sel_reg == tfi_pkg::MODE_NORMAL) ||
            (waveform_mode_sel_reg == tfi_pkg::MODE_CTC_CMP_A) ||
            (waveform_mode_sel_reg == tfi_pkg::MODE_CTC_CAPTURE)) begin
         overflow_event = counter_wrap_i;
      end else begin
         overflow_event = pwm_flag_point_i;
      end
   end

   // set and clear vectors in flag layout
   always_comb begin
      set_vec = 8'h00;
      set_vec[tfi_pkg::BIT_CAPTURE] = capture_is_top ? top_event :
         pin_event;
      set_vec[tfi_pkg::BIT_MATCH_C] = match_c;
      set_vec[tfi_pkg::BIT_MATCH_B] = match_b;
      set_vec[tfi_pkg::BIT_MATCH_A] = match_a;
      set_vec[tfi_pkg::BIT_OVERFLOW] = overflow_event;
      clear_vec = 8'h00;
      clear_vec[tfi_pkg::BIT_CAPTURE] = vector_ack_i[4];
      clear_vec[tfi_pkg::BIT_MATCH_C] = vector_ack_i[3];
      clear_vec[tfi_pkg::BIT_MATCH_B] = vector_ack_i[2];
      clear_vec[tfi_pkg::BIT_MATCH_A] = vector_ack_i[1];
      clear_vec[tfi_pkg::BIT_OVERFLOW] = vector_ack_i[0];
      if (flags_wr) begin
         clear_vec = clear_vec | reg_wdata_i;
      end
      clear_vec = clear_vec & tfi_pkg::FLAG_MASK;
   end

   // sticky flags, set wins over any clear in the same cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_reg <= tfi_pkg::FLAGS_RESET;
      end else begin
         flags_reg <= ((flags_reg & ~clear_vec) | set_vec) &
            tfi_pkg::FLAG_MASK;
      end
   end

   // capture word taken with the flag on a pin event
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         capture_value_reg <= tfi_pkg::WORD_RESET;
      end else if (!capture_is_top && pin_event) begin
         capture_value_reg <= counter_value_i;
      end else if (reg_write_i &&
            reg_addr_i == tfi_pkg::OFF_CAPTURE_LO) begin
         capture_value_reg[7:0] <= reg_wdata_i;
      end else if (reg_write_i &&
            reg_addr_i == tfi_pkg::OFF_CAPTURE_HI) begin
         capture_value_reg[15:8] <= reg_wdata_i;
      end
   end

   // enable and mode registers, spare bits never stored
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_reg <= tfi_pkg::ENABLE_RESET;
         waveform_mode_sel_reg <= tfi_pkg::MODE_RESET;
      end else if (reg_write_i) begin
         if (reg_addr_i == tfi_pkg::OFF_IRQ_ENABLE) begin
            enable_reg <= reg_wdata_i & tfi_pkg::FLAG_MASK;
         end
         if (reg_addr_i == tfi_pkg::OFF_MODE) begin
            waveform_mode_sel_reg <= reg_wdata_i[3:0];
         end
      end
   end

   // compare words, written a byte at a time
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         compare_a_value_reg <= tfi_pkg::WORD_RESET;
         compare_b_value_reg <= tfi_pkg::WORD_RESET;
         compare_c_value_reg <= tfi_pkg::WORD_RESET;
      end else if (reg_write_i) begin
         unique case (reg_addr_i)
            tfi_pkg::OFF_COMPARE_A_LO: compare_a_value_reg[7:0] <= reg_wdata_i;
            tfi_pkg::OFF_COMPARE_A_HI:
               compare_a_value_reg[15:8] <= reg_wdata_i;
            tfi_pkg::OFF_COMPARE_B_LO: compare_b_value_reg[7:0] <= reg_wdata_i;
            tfi_pkg::OFF_COMPARE_B_HI:
               compare_b_value_reg[15:8] <= reg_wdata_i;
            tfi_pkg::OFF_COMPARE_C_LO: compare_c_value_reg[7:0] <= reg_wdata_i;
            tfi_pkg::OFF_COMPARE_C_HI:
               compare_c_value_reg[15:8] <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // counter write goes out to the counter unit on the high byte;
   // the block then holds until the next tick so that tick has no match
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         counter_wbuf_reg <= 8'h00;
         counter_write_o <= 1'b0;
         counter_wdata_o <= tfi_pkg::WORD_RESET;
         block_match_reg <= 1'b0;
      end else begin
         counter_write_o <= 1'b0;
         if (reg_write_i && reg_addr_i == tfi_pkg::OFF_COUNTER_LO) begin
            counter_wbuf_reg <= reg_wdata_i;
         end
         if (reg_write_i && reg_addr_i == tfi_pkg::OFF_COUNTER_HI) begin
            counter_write_o <= 1'b1;
            counter_wdata_o <= {reg_wdata_i, counter_wbuf_reg};
            block_match_reg <= 1'b1;
         end else if (timer_tick_i) begin
            block_match_reg <= 1'b0;
         end
      end
   end

   // read mux, unmapped reads give zero
   always_comb begin
      unique case (reg_addr_i)
         tfi_pkg::OFF_IRQ_ENABLE: rdata_next = enable_reg;
         tfi_pkg::OFF_IRQ_FLAGS: rdata_next = flags_reg;
         tfi_pkg::OFF_MODE: rdata_next = {4'h0, waveform_mode_sel_reg};
         tfi_pkg::OFF_COUNTER_LO: rdata_next = counter_value_i[7:0];
         tfi_pkg::OFF_COUNTER_HI: rdata_next = counter_value_i[15:8];
         tfi_pkg::OFF_CAPTURE_LO: rdata_next = capture_value_reg[7:0];
         tfi_pkg::OFF_CAPTURE_HI: rdata_next = capture_value_reg[15:8];
         tfi_pkg::OFF_COMPARE_A_LO: rdata_next = compare_a_value_reg[7:0];
         tfi_pkg::OFF_COMPARE_A_HI: rdata_next = compare_a_value_reg[15:8];
         tfi_pkg::OFF_COMPARE_B_LO: rdata_next = compare_b_value_reg[7:0];
         tfi_pkg::OFF_COMPARE_B_HI: rdata_next = compare_b_value_reg[15:8];
         tfi_pkg::OFF_COMPARE_C_LO: rdata_next = compare_c_value_reg[7:0];
         tfi_pkg::OFF_COMPARE_C_HI: rdata_next = compare_c_value_reg[15:8];
         default: rdata_next = 8'h00;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         reg_rdata_o <= rdata_next;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // requests: enable and global flag and sticky flag
   assign irq_req_o[4] = global_irq_en_i &&
      enable_reg[tfi_pkg::BIT_CAPTURE] &&
      flags_reg[tfi_pkg::BIT_CAPTURE];
   assign irq_req_o[3] = global_irq_en_i &&
      enable_reg[tfi_pkg::BIT_MATCH_C] &&
      flags_reg[tfi_pkg::BIT_MATCH_C];
   assign irq_req_o[2] = global_irq_en_i &&
      enable_reg[tfi_pkg::BIT_MATCH_B] &&
      flags_reg[tfi_pkg::BIT_MATCH_B];
   assign irq_req_o[1] = global_irq_en_i &&
      enable_reg[tfi_pkg::BIT_MATCH_A] &&
      flags_reg[tfi_pkg::BIT_MATCH_A];
   assign irq_req_o[0] = global_irq_en_i &&
      enable_reg[tfi_pkg::BIT_OVERFLOW] &&
      flags_reg[tfi_pkg::BIT_OVERFLOW];
   assign irq_o = |irq_req_o;

   // assertions, all on the one clock and quiet while reset is low
   default clocking chk_cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_cnt_write;
      reg_write_i && reg_addr_i == tfi_pkg::OFF_COUNTER_HI;
   endsequence

   // pin edge outside the capture-as-top modes
   sequence s_pin_capture;
      !capture_is_top && pin_event;
   endsequence

   chk_req_capture: assert property (
      irq_req_o[4] == (global_irq_en_i && enable_reg[5] && flags_reg[5]))
      else $error("capture request mismatch");
   chk_req_match_c: assert property (
      irq_req_o[3] == (global_irq_en_i && enable_reg[3] && flags_reg[3]))
      else $error("match c request mismatch");
   chk_req_match_b: assert property (
      irq_req_o[2] == (global_irq_en_i && enable_reg[2] && flags_reg[2]))
      else $error("match b request mismatch");
   chk_req_match_a: assert property (
      irq_req_o[1] == (global_irq_en_i && enable_reg[1] && flags_reg[1]))
      else $error("match a request mismatch");
   chk_req_overflow: assert property (
      irq_req_o[0] == (global_irq_en_i && enable_reg[0] && flags_reg[0]))
      else $error("overflow request mismatch");
   chk_spare_zero: assert property (
      (flags_reg & ~tfi_pkg::FLAG_MASK) == 8'h00)
      else $error("spare flag bit set");
   chk_pin_capture: assert property (
      s_pin_capture |=> flags_reg[5] &&
         capture_value_reg == $past(counter_value_i))
      else $error("pin capture not taken");
   chk_top_capture: assert property (
      top_event |=> flags_reg[5])
      else $error("top capture flag not set");
   // pin is cut off in top modes, so only software may move the word
   chk_top_no_copy: assert property (
      capture_is_top && !reg_write_i |=>
      capture_value_reg == $past(capture_value_reg))
      else $error("capture word moved in top mode");
   chk_ack_clears: assert property (
      vector_ack_i[1] && !set_vec[1] |=> !flags_reg[1])
      else $error("vector entry left flag set");
   chk_match_c_set: assert property (
      timer_tick_i && !block_match_reg &&
      counter_value_i == compare_c_value_reg |=> flags_reg[3])
      else $error("match c flag not set");
   chk_match_b_set: assert property (
      timer_tick_i && !block_match_reg &&
      counter_value_i == compare_b_value_reg |=> flags_reg[2])
      else $error("match b flag not set");
   chk_match_a_set: assert property (
      timer_tick_i && !block_match_reg &&
      counter_value_i == compare_a_value_reg |=> flags_reg[1])
      else $error("match a flag not set");
   chk_force_no_set: assert property (
      force_match_b_strobe_i && !flags_reg[2] && !match_b |=> !flags_reg[2])
      else $error("force strobe set flag");
   chk_force_a_none: assert property (
      force_match_a_strobe_i && !flags_reg[1] && !match_a |=>
      !flags_reg[1])
      else $error("force a strobe set flag");
   chk_force_c_none: assert property (
      force_match_c_strobe_i && !flags_reg[3] && !match_c |=>
      !flags_reg[3])
      else $error("force c strobe set flag");
   // wrap only counts in the non-pwm modes
   chk_wrap_flag: assert property (
      counter_wrap_i &&
      (waveform_mode_sel_reg == tfi_pkg::MODE_NORMAL ||
      waveform_mode_sel_reg == tfi_pkg::MODE_CTC_CMP_A ||
      waveform_mode_sel_reg == tfi_pkg::MODE_CTC_CAPTURE) |=> flags_reg[0])
      else $error("wrap did not set overflow flag");
   // block stands from the write until the next tick has passed
   chk_write_blocks: assert property (
      s_cnt_write |=> block_match_reg && !match_a && !match_b && !match_c)
      else $error("match after counter write");
   chk_set_wins: assert property (
      set_vec[0] |=> flags_reg[0])
      else $error("set lost to clear");
   chk_zero_write: assert property (
      flags_wr && reg_wdata_i == 8'h00 && vector_ack_i == 5'h00 |=>
      (flags_reg & $past(flags_reg)) == $past(flags_reg))
      else $error("zero write cleared a flag");
endmodule
`default_nettype wire

//--- tfi_core_model.sv
// core interrupt model: takes requests and pulses vector entry acks
`timescale 1ns/1ps
`default_nettype none
module tfi_core_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [4:0] irq_req_i,
   input wire logic ack_en_i,
   input wire logic [3:0] ack_delay_i,
   output logic [4:0] vector_ack_o,
   output logic [7:0] ack_count_o
);
   logic [3:0] wait_reg; // cycles spent waiting on a pending request

   // one vector entry at a time, lowest pending source first
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vector_ack_o <= 5'h00;
         wait_reg <= 4'h0;
         ack_count_o <= 8'h00;
      end else if (vector_ack_o != 5'h00) begin
         // ack lasts one cycle; the request drops after it lands
         vector_ack_o <= 5'h00;
         wait_reg <= 4'h0;
      end else if (ack_en_i && irq_req_i != 5'h00) begin
         if (wait_reg >= ack_delay_i) begin
            vector_ack_o <= irq_req_i & (~irq_req_i + 5'h01);
            ack_count_o <= ack_count_o + 8'h01;
         end else begin
            wait_reg <= wait_reg + 4'h1; // slow core answer
         end
      end else begin
         wait_reg <= 4'h0;
      end
   end
endmodule
`default_nettype wire

//--- test_tfi_irq_flags.sv
// testbench: register port, flag events, requests and vector clearing
`timescale 1ns/1ps
`default_nettype none
module test_tfi_irq_flags;
   // event row: mode, counter, tick, wrap, pwm point, forces, flags
   typedef struct packed {
      logic [3:0] mode;
      logic [15:0] cnt;
      logic tick;
      logic wrap;
      logic pwm;
      logic [2:0] frc;
      logic [7:0] exp;
   } tfi_row_t;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_write_i = 1'b0;
   logic reg_read_i = 1'b0;
   logic timer_tick_i = 1'b0;
   logic [15:0] counter_value_i = 16'h0000;
   logic counter_wrap_i = 1'b0;
   logic pwm_flag_point_i = 1'b0;
   logic capture_input_pin_i = 1'b0;
   logic capture_edge_i = 1'b1;
   logic [2:0] force_i = 3'h0; // c, b, a strobes
   logic global_irq_en_i = 1'b1;
   logic ack_en = 1'b0; // core model answers only when set
   logic [3:0] ack_delay = 4'h0;
   logic [4:0] vector_ack_i;
   logic [7:0] reg_rdata_o;
   logic [4:0] irq_req_o;
   logic irq_o;
   logic counter_write_o;
   logic [15:0] counter_wdata_o;
   logic [7:0] ack_count;
   int n_fail = 0;
   int tests_run = 0;
   // compares A=0011 B=0022 C=0033, capture word 0044
   tfi_row_t rows [13] = '{
      '{4'h0, 16'h0011, 1'b1, 1'b0, 1'b0, 3'h0, 8'h02},
      '{4'h0, 16'h0022, 1'b1, 1'b0, 1'b0, 3'h0, 8'h04},
      '{4'h0, 16'h0033, 1'b1, 1'b0, 1'b0, 3'h0, 8'h08},
      '{4'h0, 16'h0011, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00},
      '{4'h0, 16'h0000, 1'b1, 1'b0, 1'b0, 3'h7, 8'h00},
      '{4'h0, 16'h0000, 1'b1, 1'b1, 1'b0, 3'h0, 8'h01},
      '{4'h4, 16'h0000, 1'b1, 1'b1, 1'b0, 3'h0, 8'h01},
      '{4'h0, 16'h0000, 1'b1, 1'b0, 1'b1, 3'h0, 8'h00},
      '{4'hE, 16'h0000, 1'b1, 1'b0, 1'b1, 3'h0, 8'h01},
      '{4'hE, 16'h0000, 1'b1, 1'b1, 1'b0, 3'h0, 8'h00},
      '{4'hC, 16'h0044, 1'b1, 1'b0, 1'b0, 3'h0, 8'h20},
      '{4'hA, 16'h0044, 1'b1, 1'b0, 1'b0, 3'h0, 8'h20},
      '{4'h0, 16'h0044, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00}};

   tfi_irq_flags DUT (.clk_i(clk_i), .resetn_i(resetn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .timer_tick_i(timer_tick_i),
      .counter_value_i(counter_value_i), .counter_wrap_i(counter_wrap_i),
      .pwm_flag_point_i(pwm_flag_point_i),
      .capture_input_pin_i(capture_input_pin_i),
      .capture_edge_i(capture_edge_i),
      .force_match_a_strobe_i(force_i[0]),
      .force_match_b_strobe_i(force_i[1]),
      .force_match_c_strobe_i(force_i[2]),
      .global_irq_en_i(global_irq_en_i), .vector_ack_i(vector_ack_i),
      .irq_req_o(irq_req_o), .irq_o(irq_o),
      .counter_write_o(counter_write_o),
      .counter_wdata_o(counter_wdata_o));

   tfi_core_model core (.clk_i(clk_i), .resetn_i(resetn_i),
      .irq_req_i(irq_req_o), .ack_en_i(ack_en), .ack_delay_i(ack_delay),
      .vector_ack_o(vector_ack_i), .ack_count_o(ack_count));

   // 4 ns clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic check(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // single-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask

   // read: data stands only in the cycle after the strobe
   task automatic chk_reg(input string nm, input logic [3:0] a,
                          input logic [7:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 check(nm, {8'h00, reg_rdata_o}, {8'h00, exp});
   endtask

   // one cycle of timer events
   task automatic ev(input tfi_row_t r);
      @(posedge clk_i);
      counter_value_i <= r.cnt;
      timer_tick_i <= r.tick;
      counter_wrap_i <= r.wrap;
      pwm_flag_point_i <= r.pwm;
      force_i <= r.frc;
      @(posedge clk_i);
      timer_tick_i <= 1'b0;
      counter_wrap_i <= 1'b0;
      pwm_flag_point_i <= 1'b0;
      force_i <= 3'h0;
   endtask

   // edge choice settles a cycle before the pin moves, then sync delay
   task automatic pin(input logic e, input logic v, input logic [15:0] c);
      @(posedge clk_i);
      capture_edge_i <= e;
      counter_value_i <= c;
      @(posedge clk_i);
      capture_input_pin_i <= v;
      repeat (8) @(posedge clk_i);
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog: the whole run needs well under 3000 cycles
   initial begin
      #40000;
      n_fail++;
      results();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      chk_reg("flags rst", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      chk_reg("enable rst", tfi_pkg::OFF_IRQ_ENABLE,
         tfi_pkg::ENABLE_RESET);
      wr(tfi_pkg::OFF_IRQ_ENABLE, 8'hFF);
      chk_reg("enable", tfi_pkg::OFF_IRQ_ENABLE, tfi_pkg::FLAG_MASK);
      chk_reg("unmapped", 4'hF, 8'h00);
      wr(tfi_pkg::OFF_IRQ_FLAGS, 8'hFF);
      chk_reg("spare bits", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(4'h7 + 4'(2 * i), 8'h11 * 8'(i + 1)); // compares a, b, c
         wr(4'h8 + 4'(2 * i), 8'h00);
      end
      wr(4'h5, 8'h44); // capture word written last wins
      $display("test registers finished");
      foreach (rows[i]) begin
         wr(tfi_pkg::OFF_MODE, {4'h0, rows[i].mode});
         ev(rows[i]);
         repeat (2) @(posedge clk_i);
         #1 check("req", {11'h0, irq_req_o},
               {11'h0, rows[i].exp[5], rows[i].exp[3:0]});
         check("irq", {15'h0, irq_o}, {15'h0, |rows[i].exp});
         @(posedge clk_i);
         global_irq_en_i <= 1'b0;
         @(posedge clk_i);
         #1 check("req off", {11'h0, irq_req_o}, 16'h0000);
         @(posedge clk_i);
         global_irq_en_i <= 1'b1;
         chk_reg("flags", tfi_pkg::OFF_IRQ_FLAGS,
            rows[i].exp);
         wr(tfi_pkg::OFF_IRQ_FLAGS, 8'hFF);
         chk_reg("cleared", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      end
      $display("test event table finished");
      wr(tfi_pkg::OFF_MODE, 8'h00);
      pin(1'b1, 1'b1, 16'h1234);
      chk_reg("cap rise", tfi_pkg::OFF_IRQ_FLAGS, 8'h20);
      chk_reg("cap lo", tfi_pkg::OFF_CAPTURE_LO, 8'h34);
      chk_reg("cap hi", tfi_pkg::OFF_CAPTURE_HI, 8'h12);
      wr(tfi_pkg::OFF_IRQ_FLAGS, 8'h20);
      pin(1'b1, 1'b0, 16'h1234);
      pin(1'b0, 1'b1, 16'h5678);
      chk_reg("wrong edges", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      pin(1'b0, 1'b0, 16'h5678);
      chk_reg("cap fall", tfi_pkg::OFF_IRQ_FLAGS, 8'h20);
      chk_reg("cap lo2", tfi_pkg::OFF_CAPTURE_LO, 8'h78);
      wr(tfi_pkg::OFF_IRQ_FLAGS, 8'h20);
      wr(tfi_pkg::OFF_MODE, {4'h0, tfi_pkg::MODE_CTC_CAPTURE});
      pin(1'b1, 1'b1, 16'h0001);
      chk_reg("pin ignored", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      wr(tfi_pkg::OFF_MODE, 8'h00);
      pin(1'b1, 1'b0, 16'h0001);
      $display("test capture finished");
      // slow core: only channel A enabled, B stays pending
      wr(tfi_pkg::OFF_IRQ_ENABLE, 8'h02);
      @(posedge clk_i);
      ack_delay <= 4'h3;
      ack_en <= 1'b1;
      ev(rows[0]);
      ev(rows[1]);
      repeat (10) @(posedge clk_i);
      chk_reg("acked a", tfi_pkg::OFF_IRQ_FLAGS, 8'h04);
      check("acks", {8'h00, ack_count}, 16'h0001);
      @(posedge clk_i);
      ack_delay <= 4'h0;
      wr(tfi_pkg::OFF_IRQ_ENABLE, 8'h04);
      repeat (6) @(posedge clk_i);
      chk_reg("acked b", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      check("acks2", {8'h00, ack_count}, 16'h0002);
      @(posedge clk_i);
      ack_en <= 1'b0;
      wr(tfi_pkg::OFF_IRQ_ENABLE, 8'hFF);
      $display("test vector ack finished");
      ev(rows[0]);
      wr(tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      chk_reg("zero write", tfi_pkg::OFF_IRQ_FLAGS, 8'h02);
      // clear write and a new match land on the same edge
      @(posedge clk_i);
      reg_addr_i <= tfi_pkg::OFF_IRQ_FLAGS;
      reg_wdata_i <= 8'h02;
      reg_write_i <= 1'b1;
      counter_value_i <= 16'h0011;
      timer_tick_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
      timer_tick_i <= 1'b0;
      chk_reg("set wins", tfi_pkg::OFF_IRQ_FLAGS, 8'h02);
      wr(tfi_pkg::OFF_IRQ_FLAGS, 8'hFF);
      $display("test set priority finished");
      wr(tfi_pkg::OFF_COUNTER_LO, 8'h11);
      wr(tfi_pkg::OFF_COUNTER_HI, 8'h00);
      #1;
      for (int k = 0; k < 4 && counter_write_o !== 1'b1; k++) begin
         @(posedge clk_i);
         #1;
      end
      check("cnt load", {15'h0, counter_write_o}, 16'h0001);
      check("cnt word", counter_wdata_o, 16'h0011);
      ev(rows[0]);
      chk_reg("blocked", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      ev(rows[0]);
      chk_reg("unblocked", tfi_pkg::OFF_IRQ_FLAGS, 8'h02);
      $display("test counter write finished");
      // second reset in mid-run with a flag and enables set
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      chk_reg("flags rst2", tfi_pkg::OFF_IRQ_FLAGS, 8'h00);
      chk_reg("en rst2", tfi_pkg::OFF_IRQ_ENABLE,
         tfi_pkg::ENABLE_RESET);
      $display("test reset finished");
      results();
   end
endmodule
`default_nettype wire
